// ### design/altmode_xbar_pkg.sv
package altmode_xbar_pkg;

    // serial target address, upper five bits
    localparam logic [4:0]  TARGET_ADDR_UPPER = 5'h15;
    // identification byte: value is arbitrary
    localparam logic [7:0]  ID_BYTE_DEFAULT   = 8'ha5;

    // route code layout and values
    localparam int          ROUTE_W           = 3;
    localparam int          RESERVED_W        = 5;
    localparam int          CODE_FLIP_BIT     = 0;
    localparam int          CODE_VIDEO_BIT    = 1;
    localparam int          CODE_USB_BIT      = 2;
    localparam logic [2:0]  ROUTE_RESET       = 3'h0;
    localparam logic [2:0]  CODE_OFF          = 3'h0;
    localparam logic [2:0]  CODE_IDLE         = 3'h1;
    localparam logic [2:0]  CODE_LANES4       = 3'h2;
    localparam logic [2:0]  CODE_LANES4_FLIP  = 3'h3;
    localparam logic [2:0]  CODE_USB          = 3'h4;
    localparam logic [2:0]  CODE_USB_FLIP     = 3'h5;
    localparam logic [2:0]  CODE_LANES2       = 3'h6;
    localparam logic [2:0]  CODE_LANES2_FLIP  = 3'h7;

    // connector group one-hot switch vectors: {rx2, rx1, tx2, tx1}
    localparam int          GRP_W             = 4;
    localparam int          LANES             = 4;
    localparam logic [3:0]  SW_TX1            = 4'h1;
    localparam logic [3:0]  SW_TX2            = 4'h2;
    localparam logic [3:0]  SW_RX1            = 4'h4;
    localparam logic [3:0]  SW_RX2            = 4'h8;
    localparam logic [1:0]  PAIR_ONE          = 2'h1;
    localparam logic [1:0]  PAIR_TWO          = 2'h2;
    // lane maps, lane 3 in the top nibble
    localparam logic [15:0] SRC_LANE_MAP      = {SW_RX1, SW_TX1, SW_TX2, SW_RX2};
    localparam logic [15:0] SNK_LANE_MAP      = {SW_TX1, SW_RX1, SW_RX2, SW_TX2};

    // serial byte framing
    localparam int          BIT_CNT_W         = 3;
    localparam logic [2:0]  LAST_BIT          = 3'h7;

    // link reset hold after a start condition, kept below the start hold time
    localparam int          CLK_PERIOD_PS     = 10000;
    localparam int          LINK_HOLD_NS      = 40;
    localparam int          LINK_HOLD_CYCLES  =
        (LINK_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          HOLD_CNT_W        = 3;

    typedef enum logic [2:0] {
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WR_ACK,
        ST_READ,
        ST_RD_ACK,
        ST_IGNORE
    } link_state_e;

endpackage

// ### design/sync2.sv
`timescale 1ns/1ps
module sync2
    import altmode_xbar_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ### design/route_decoder.sv
`timescale 1ns/1ps
module route_decoder
    import altmode_xbar_pkg::*;
#(
    parameter bit SINK_USE = 1'b0
) (
    // route code
    input  wire logic [ROUTE_W-1:0]     code,
    // switch closures
    output logic      [1:0]             usb_tx_sw,
    output logic      [1:0]             usb_rx_sw,
    output logic      [LANES*GRP_W-1:0] lane_sw,
    output logic      [1:0]             aux_p_sw,
    output logic      [1:0]             aux_n_sw,
    output logic                        power_en
);

    logic       usb;
    logic       video;
    logic       flip;
    logic [1:0] usb_grp;
    logic       aux_swap;

    assign usb      = code[CODE_USB_BIT];
    assign video    = code[CODE_VIDEO_BIT];
    assign flip     = code[CODE_FLIP_BIT];
    assign usb_grp  = flip ? PAIR_TWO : PAIR_ONE;
    assign usb_tx_sw = usb ? usb_grp : 2'h0;
    assign usb_rx_sw = usb ? usb_grp : 2'h0;
    // sink mapping reverses the aux pair relative to source
    assign aux_swap = flip ^ SINK_USE;
    assign aux_p_sw = !video ? 2'h0 : (aux_swap ? PAIR_TWO : PAIR_ONE);
    assign aux_n_sw = !video ? 2'h0 : (aux_swap ? PAIR_ONE : PAIR_TWO);
    assign power_en = (code != CODE_OFF);

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [GRP_W-1:0] base;
        logic [GRP_W-1:0] swapped;
        logic             en;
        assign base    = SINK_USE ? SNK_LANE_MAP[i*GRP_W +: GRP_W]
                                  : SRC_LANE_MAP[i*GRP_W +: GRP_W];
        // swap group 1 and group 2 for flipped codes
        assign swapped = {base[2], base[3], base[0], base[1]};
        // lanes 2 and 3 only in the four-lane codes
        assign en      = video && ((i < 2) || !usb);
        assign lane_sw[i*GRP_W +: GRP_W] = !en ? '0 : (flip ? swapped : base);
    end

endmodule

// ### design/altmode_crossbar_config_decoder.sv
`timescale 1ns/1ps
module altmode_crossbar_config_decoder
    import altmode_xbar_pkg::*;
#(
    parameter bit         SINK_USE = 1'b0,
    parameter logic [7:0] ID_BYTE  = ID_BYTE_DEFAULT
) (
    // clocks and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   serial_clk,
    // control pins
    input  wire logic                   control_source_select,
    input  wire logic                   serial_level_select,
    input  wire logic [ROUTE_W-1:0]     route_code,
    input  wire logic                   addr_strap_hi,
    input  wire logic                   addr_strap_lo,
    // serial data pin
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    // status
    output logic                        serial_mode,
    output logic                        io_level_3v3,
    output logic                        power_enable,
    // switch closures
    output logic      [1:0]             sys_usb_transmit_sw,
    output logic      [1:0]             sys_usb_receive_sw,
    output logic      [LANES*GRP_W-1:0] video_lane_sw,
    output logic      [1:0]             aux_p_sw,
    output logic      [1:0]             aux_n_sw
);

    // ---------------- reference domain: pin synchronisers ----------------
    logic [ROUTE_W+3:0]         pins_s;
    logic                       ctl_src;
    logic                       lvl_sel;
    logic [ROUTE_W-1:0]         pin_route;
    logic                       scl_s;
    logic                       sda_s;
    logic                       scl_d;
    logic                       sda_d;

    sync2 #(
        .WIDTH (ROUTE_W + 4)
    ) u_pin_sync (
        .clk   (ref_clk),
        .rst_b (rst_b),
        .d     ({control_source_select, serial_level_select, route_code,
                 serial_clk, sda_in}),
        .q     (pins_s)
    );

    assign {ctl_src, lvl_sel, pin_route, scl_s, sda_s} = pins_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ---------------- reference domain: frame detection ----------------
    // the link logic is held in reset between frames; a start releases it
    // after a short hold while the serial clock still stands high
    logic                       start_det;
    logic                       stop_det;
    logic                       link_active;
    logic [HOLD_CNT_W-1:0]      hold_cnt;
    logic                       link_rst_b;

    assign start_det = ctl_src && scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = ctl_src && scl_s && scl_d && !sda_d && sda_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_active <= 1'b0;
        end else if (!ctl_src || stop_det) begin
            link_active <= 1'b0;
        end else if (start_det) begin
            link_active <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= '0;
        end else if (start_det) begin
            hold_cnt <= HOLD_CNT_W'(LINK_HOLD_CYCLES);
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_rst_b <= 1'b0;
        end else begin
            link_rst_b <= link_active && !start_det && !stop_det && (hold_cnt == '0);
        end
    end

    // ---------------- link domain: serial target ----------------
    logic [1:0]                 strap_s;
    link_state_e                state;
    logic [BIT_CNT_W-1:0]       bit_cnt;
    logic [6:0]                 shreg;
    logic                       rd_sel;
    logic [7:0]                 rx_byte;
    logic [7:0]                 tx_byte;
    logic [ROUTE_W-1:0]         shadow;
    logic                       wr_tgl;
    logic                       addr_match;

    sync2 #(
        .WIDTH (2)
    ) u_strap_sync (
        .clk   (serial_clk),
        .rst_b (rst_b),
        .d     ({addr_strap_hi, addr_strap_lo}),
        .q     (strap_s)
    );

    assign rx_byte    = {shreg, sda_in};
    assign addr_match = (rx_byte[7:1] == {TARGET_ADDR_UPPER, strap_s});
    // upper bits of the selection byte always read as zero
    assign tx_byte    = rd_sel ? {{RESERVED_W{1'b0}}, shadow} : ID_BYTE;

    always_ff @(posedge serial_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            state   <= ST_ADDR;
            bit_cnt <= '0;
            shreg   <= '0;
            rd_sel  <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    shreg   <= rx_byte[6:0];
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        state <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt <= '0;
                    rd_sel  <= 1'b0;
                    state   <= shreg[0] ? ST_READ : ST_WRITE;
                end
                ST_WRITE: begin
                    shreg   <= rx_byte[6:0];
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        state <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    // only one data byte per write; later bytes get no ack
                    state <= ST_IGNORE;
                end
                ST_READ: begin
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        state <= ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    bit_cnt <= '0;
                    rd_sel  <= 1'b1;
                    state   <= sda_in ? ST_IGNORE : ST_READ;
                end
                default: begin
                    state <= ST_IGNORE;
                end
            endcase
        end
    end

    // selection byte and write event survive between frames
    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow <= ROUTE_RESET;
            wr_tgl <= 1'b0;
        end else if (link_rst_b && state == ST_WRITE && bit_cnt == LAST_BIT) begin
            shadow <= rx_byte[ROUTE_W-1:0];
            wr_tgl <= !wr_tgl;
        end
    end

    // open-drain drive changes on the falling edge
    always_ff @(negedge serial_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR_ACK: sda_oe <= 1'b1;
                ST_WR_ACK:   sda_oe <= 1'b1;
                ST_READ:     sda_oe <= !tx_byte[3'(LAST_BIT - bit_cnt)];
                default:     sda_oe <= 1'b0;
            endcase
        end
    end

    // ---------------- reference domain: selection register ----------------
    logic                       wr_tgl_s;
    logic                       wr_tgl_d;
    logic                       wr_evt;
    logic [ROUTE_W-1:0]         route_sel;
    logic [ROUTE_W-1:0]         eff_code;

    sync2 #(
        .WIDTH (1)
    ) u_wr_sync (
        .clk   (ref_clk),
        .rst_b (rst_b),
        .d     (wr_tgl),
        .q     (wr_tgl_s)
    );

    assign wr_evt = wr_tgl_s ^ wr_tgl_d;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_tgl_d  <= 1'b0;
            route_sel <= ROUTE_RESET;
        end else begin
            wr_tgl_d <= wr_tgl_s;
            // shadow is stable for many serial bits after the toggle
            if (wr_evt) begin
                route_sel <= shadow;
            end
        end
    end

    assign eff_code = ctl_src ? route_sel : pin_route;

    // ---------------- decode and output registers ----------------
    logic [1:0]                 next_usb_tx;
    logic [1:0]                 next_usb_rx;
    logic [LANES*GRP_W-1:0]     next_lane;
    logic [1:0]                 next_aux_p;
    logic [1:0]                 next_aux_n;
    logic                       next_power;

    route_decoder #(
        .SINK_USE (SINK_USE)
    ) u_decoder (
        .code      (eff_code),
        .usb_tx_sw (next_usb_tx),
        .usb_rx_sw (next_usb_rx),
        .lane_sw   (next_lane),
        .aux_p_sw  (next_aux_p),
        .aux_n_sw  (next_aux_n),
        .power_en  (next_power)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_usb_transmit_sw <= '0;
            sys_usb_receive_sw  <= '0;
            video_lane_sw       <= '0;
            aux_p_sw            <= '0;
            aux_n_sw            <= '0;
            power_enable        <= 1'b0;
        end else begin
            sys_usb_transmit_sw <= next_usb_tx;
            sys_usb_receive_sw  <= next_usb_rx;
            video_lane_sw       <= next_lane;
            aux_p_sw            <= next_aux_p;
            aux_n_sw            <= next_aux_n;
            power_enable        <= next_power;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_mode  <= 1'b0;
            io_level_3v3 <= 1'b0;
            sda_out      <= 1'b0;
        end else begin
            serial_mode  <= ctl_src;
            io_level_3v3 <= ctl_src && lvl_sel;
            sda_out      <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    AST_SERIAL_LEVEL: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (ctl_src && lvl_sel) |=> (serial_mode && io_level_3v3)
    ) else $error("serial mode at 3.3V not reported");

    AST_PIN_MODE_ROUTE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!ctl_src && pin_route == CODE_USB) |=> (sys_usb_transmit_sw == PAIR_ONE)
    ) else $error("pin route code not applied");

    AST_OPEN_CODES: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_OFF || eff_code == CODE_IDLE) |=>
            (sys_usb_transmit_sw == '0 && sys_usb_receive_sw == '0 &&
             video_lane_sw == '0 && aux_p_sw == '0 && aux_n_sw == '0)
    ) else $error("switch closed in an open code");

    AST_POWER_STATE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_OFF) ##1 (eff_code == CODE_IDLE) |=>
            ($past(power_enable) == 1'b0 && power_enable)
    ) else $error("power state wrong for open codes");

    AST_USB_FLIP: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_USB_FLIP || eff_code == CODE_LANES2_FLIP) |=>
            (sys_usb_transmit_sw == PAIR_TWO && sys_usb_receive_sw == PAIR_TWO)
    ) else $error("flipped usb not on group 2");

    AST_FOUR_LANE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_LANES4) |=>
            (video_lane_sw == (SINK_USE ? SNK_LANE_MAP : SRC_LANE_MAP) &&
             sys_usb_transmit_sw == '0)
    ) else $error("four-lane mapping wrong");

    AST_TWO_LANE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_LANES2_FLIP) |=>
            (video_lane_sw[2*GRP_W +: 2*GRP_W] == '0 &&
             video_lane_sw[GRP_W-1:0] != '0)
    ) else $error("two-lane code closed lanes 2 or 3");

    AST_AUX_SWAP: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (eff_code == CODE_LANES2) |=>
            (aux_p_sw == (SINK_USE ? PAIR_TWO : PAIR_ONE) && aux_n_sw == ~aux_p_sw)
    ) else $error("aux pair mapping wrong");

    AST_WRITE_TAKEN: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        wr_evt |=> (route_sel == $past(shadow))
    ) else $error("serial write not taken into selection");

    AST_LINK_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        start_det |=> !link_rst_b [*4]
    ) else $error("link released too early after start");

endmodule

// ### test/serial_ctrl_model.sv
`timescale 1ns/1ps
module serial_ctrl_model (
    // serial bus
    output logic      scl,
    output logic      pull_low,
    input  wire logic sda
);
    // quarter of a 125 ns bit
    localparam realtime Q = 31.25;

    initial begin
        scl      = 1'b1;
        pull_low = 1'b0;
    end

    // start or repeated start: data falls while clock high
    task automatic start_cond();
        pull_low = 1'b0;
        #(2*Q) scl = 1'b1;
        #(2*Q) pull_low = 1'b1;
        #(4*Q) scl = 1'b0;
    endtask

    // eight bits msb first, then the ninth bit
    task automatic xfer(input logic [7:0] tx, input logic ack_out,
                        output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            #Q pull_low = ~tx[i];
            #Q scl = 1'b1;
            rx[i] = sda;
            #(2*Q) scl = 1'b0;
        end
        #Q pull_low = ack_out;
        #Q scl = 1'b1;
        ack_in = ~sda;
        #(2*Q) scl = 1'b0;
    endtask

    // stop: data rises while clock high, clock then stands high
    task automatic stop_cond();
        #Q pull_low = 1'b1;
        #Q scl = 1'b1;
        #(2*Q) pull_low = 1'b0;
        #(4*Q);
    endtask
endmodule

// ### test/altmode_crossbar_config_decoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module altmode_crossbar_config_decoder_tb_top;
    import altmode_xbar_pkg::*;
    // identification value is arbitrary
    localparam logic [7:0] ID_VAL = 8'h3c;

    logic        ref_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        ctl_sel  = 1'b0;
    logic        lvl_sel  = 1'b0;
    logic [2:0]  code_pin = 3'h0;
    logic [1:0]  strap    = 2'h0;
    logic [7:0]  d        = 8'h0;
    int          seed     = 72;
    int          n_fail   = 0;
    int          n_compared = 0;
    int          cycles   = 0;
    logic        scl, pull_low, sda, sda_out, sda_oe;
    logic        serial_mode, io_level_3v3, power_enable;
    logic [1:0]  usb_tx, usb_rx, aux_p, aux_n;
    logic [15:0] lanes;
    logic        sda_out_k, sda_oe_k, pwr_k;
    logic [1:0]  utx_k, urx_k, ap_k, an_k;
    logic [15:0] ln_k;

    // open-drain wire with pull-up, both targets on it
    assign sda = !(pull_low || (sda_oe && !sda_out) || (sda_oe_k && !sda_out_k));

    always #5 ref_clk = ~ref_clk;

    altmode_crossbar_config_decoder #(.SINK_USE(1'b0), .ID_BYTE(ID_VAL)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .serial_clk(scl),
        .control_source_select(ctl_sel), .serial_level_select(lvl_sel),
        .route_code(code_pin), .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .serial_mode(serial_mode), .io_level_3v3(io_level_3v3),
        .power_enable(power_enable), .sys_usb_transmit_sw(usb_tx),
        .sys_usb_receive_sw(usb_rx), .video_lane_sw(lanes),
        .aux_p_sw(aux_p), .aux_n_sw(aux_n)
    );

    // second target with the sink mapping on the same pins and bus
    altmode_crossbar_config_decoder #(.SINK_USE(1'b1), .ID_BYTE(ID_VAL)) i_dut_snk (
        .ref_clk(ref_clk), .rst_b(rst_b), .serial_clk(scl),
        .control_source_select(ctl_sel), .serial_level_select(lvl_sel),
        .route_code(code_pin), .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]),
        .sda_in(sda), .sda_out(sda_out_k), .sda_oe(sda_oe_k),
        .serial_mode(), .io_level_3v3(),
        .power_enable(pwr_k), .sys_usb_transmit_sw(utx_k),
        .sys_usb_receive_sw(urx_k), .video_lane_sw(ln_k),
        .aux_p_sw(ap_k), .aux_n_sw(an_k)
    );

    serial_ctrl_model i_model (
        .scl(scl), .pull_low(pull_low), .sda(sda)
    );

    // {power, usb tx, usb rx, lanes, aux p, aux n} for source or sink use
    function automatic logic [24:0] exp_out(input logic [2:0] c, input logic snk);
        logic [1:0]  u;
        logic [15:0] l;
        logic [3:0]  a;
        u = !c[2] ? 2'h0 : (c[0] ? 2'h2 : 2'h1);
        case (c)
            3'h2: l = snk ? 16'h1482 : 16'h4128;
            3'h3: l = snk ? 16'h2841 : 16'h8214;
            3'h6: l = snk ? 16'h0082 : 16'h0028;
            3'h7: l = snk ? 16'h0041 : 16'h0014;
            default: l = 16'h0000;
        endcase
        a = !c[1] ? 4'h0 : ((c[0] ^ snk) ? 4'h9 : 4'h6);
        return {c != 3'h0, u, u, l, a};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk_route(input logic [2:0] c);
        `CHK({power_enable, usb_tx, usb_rx, lanes, aux_p, aux_n}, exp_out(c, 1'b0))
        `CHK({pwr_k, utx_k, urx_k, ln_k, ap_k, an_k}, exp_out(c, 1'b1))
    endtask

    task automatic ser_write(input logic [6:0] adr, input logic [7:0] v, input logic ok);
        logic [7:0] r;
        logic       a;
        step(1);
        i_model.start_cond();
        i_model.xfer({adr, 1'b0}, 1'b0, r, a);
        `CHK(a, ok)
        i_model.xfer(v, 1'b0, r, a);
        `CHK(a, ok)
        i_model.stop_cond();
        step(6);
    endtask

    task automatic ser_read(input logic [2:0] c);
        logic [7:0] r;
        logic       a;
        step(1);
        i_model.start_cond();
        i_model.xfer({5'h15, strap, 1'b1}, 1'b0, r, a);
        `CHK(a, 1'b1)
        i_model.xfer(8'hff, 1'b1, r, a);
        `CHK(r, ID_VAL)
        i_model.xfer(8'hff, 1'b0, r, a);
        `CHK(r, {5'h00, c})
        i_model.stop_cond();
        step(1);
    endtask

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        step(16);
        rst_b = 1'b1;
        step(4);
        // pin control: every code, then random ones, level ignored
        for (int i = 0; i < 24; i++) begin
            code_pin = (i < 8) ? i[2:0] : 3'($random(seed));
            lvl_sel = 1'($random(seed));
            step(5);
            chk_route(code_pin);
            `CHK({serial_mode, io_level_3v3}, 2'h0)
        end
        ctl_sel = 1'b1;
        lvl_sel = 1'b1;
        step(5);
        `CHK({serial_mode, io_level_3v3}, 2'h3)
        chk_route(3'h0);
        ser_read(3'h0);
        // serial writes with junk in the upper bits, pins ignored
        for (int i = 0; i < 16; i++) begin
            d = (i < 8) ? {5'h1f, i[2:0]} : 8'($random(seed));
            strap = 2'($random(seed));
            code_pin = 3'($random(seed));
            ser_write({5'h15, strap}, d, 1'b1);
            chk_route(d[2:0]);
            ser_read(d[2:0]);
        end
        // wrong strap bits and wrong upper pattern are refused
        ser_write({5'h15, ~strap}, ~d, 1'b0);
        ser_write({5'h14, strap}, ~d, 1'b0);
        chk_route(d[2:0]);
        lvl_sel = 1'b0;
        step(5);
        `CHK({serial_mode, io_level_3v3}, 2'h2)
        ctl_sel = 1'b0;
        step(5);
        chk_route(code_pin);
        test_done();
    end
endmodule
